// File: dv/fskm_line_model.sv
`timescale 1ns/1ps
module fskm_line_model import fskm_pkg::*;
(
   // Clock
   input wire logic clk,
   // Commands from the bench
   input wire logic send,
   input wire logic [8:0] send_data,
   input wire logic carrier,
   // Design side
   input wire logic demod_en,
   input wire logic sample_stb,
   input wire logic [7:0] sample,
   output logic demod_valid,
   output logic [8:0] demod_data,
   output logic above_on,
   output logic above_off,
   output int stb_count,
   output int peak_hi,
   output int peak_lo
);
   initial
   begin
      demod_valid = 1'b0;
      demod_data = 9'h000;
      above_on = 1'b0;
      above_off = 1'b0;
      stb_count = 0;
      peak_hi = 0;
      peak_lo = 0;
   end

   // A disabled demodulator yields nothing; idle data flips so stale bytes never pass
   always @(posedge clk)
   begin
      demod_valid <= send & demod_en;
      demod_data <= send ? send_data : ~demod_data;
      above_on <= carrier;
      above_off <= carrier;
      if (sample_stb)
      begin
         stb_count <= stb_count + 1;
         // Signed extremes show the table's sign and full swing
         if ($signed(sample) > peak_hi)
            peak_hi <= $signed(sample);
         if ($signed(sample) < peak_lo)
            peak_lo <= $signed(sample);
      end
   end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench import fskm_pkg::*;
;
   // Design inputs
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic MODEM_EN, TX_RES, EXT_FILT_EN, LPF_ORDER_EN, TX_THR_MASK, CRC_EN, RTS;
   logic TX_WR, RX_RD, RX_CRC_ERR, UART_RX_VALID, UART_RX_BREAK, UART_TX_READY;
   logic [1:0] IF_MODE;
   logic [3:0] RX_THRESH, TX_THRESH;
   logic [8:0] TX_WR_DATA, UART_RX_DATA;
   // Design outputs and line side
   logic RX_RD_VALID, RX_RD_EMPTY, RX_RD_FULL, UART_TX_VALID, DEMOD_VALID;
   logic CARRIER_ABOVE_ON, CARRIER_ABOVE_OFF, MOD_SAMPLE_STB, MOD_ENABLE, DEMOD_ENABLE;
   logic CARRIER_DETECT, CTS, FILT_EXT_SEL, LPF_ENABLE, TX_FULL, TX_EMPTY;
   logic TX_LEVEL_FLAG, RX_FULL, RX_EMPTY, RX_LEVEL_FLAG, IRQ;
   logic [3:0] RX_RD_LEVEL;
   logic [7:0] MOD_SAMPLE;
   logic [8:0] RX_RD_DATA, TX_PEEK_DATA, UART_TX_DATA, DEMOD_DATA;
   // Bench state
   logic send = 1'b0;
   logic carrier = 1'b0;
   logic [8:0] send_data = 9'h000;
   logic [8:0] d;
   logic [5:0] c;
   int stb_count, n0, peak_hi, peak_lo;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 32'h1daf;
   logic [8:0] q[$];

   fskm_top uut (.*);

   fskm_line_model line (.clk(CLK), .send(send), .send_data(send_data), .carrier(carrier),
      .demod_en(DEMOD_ENABLE), .sample_stb(MOD_SAMPLE_STB), .sample(MOD_SAMPLE),
      .demod_valid(DEMOD_VALID), .demod_data(DEMOD_DATA), .above_on(CARRIER_ABOVE_ON),
      .above_off(CARRIER_ABOVE_OFF), .stb_count(stb_count), .peak_hi(peak_hi),
      .peak_lo(peak_lo));

   // Clock
   always #(CLK_PERIOD_NS / 2.0) CLK = ~CLK;

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard, sized well above the longest scenario mix
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fails++;
         test_done();
      end
   end

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Sample 1 ns after the edge so flop updates have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic do_reset();
      @(posedge CLK);
      RSTN <= 1'b0;
      q.delete();
      wait_cyc(8);
      @(posedge CLK);
      RSTN <= 1'b1;
      wait_cyc(2);
   endtask

   task automatic wr_tx(input logic [8:0] v);
      @(posedge CLK);
      TX_WR <= 1'b1;
      TX_WR_DATA <= v;
      @(posedge CLK);
      TX_WR <= 1'b0;
      TX_WR_DATA <= ~v;
      wait_cyc(3);
   endtask

   // Read returns status of the FIFO before the dequeue
   task automatic rd_rx(input logic err, input logic en);
      int n;
      n = 0;
      c = 6'(q.size());
      @(posedge CLK);
      RX_RD <= 1'b1;
      RX_CRC_ERR <= err;
      CRC_EN <= en;
      @(posedge CLK);
      RX_RD <= 1'b0;
      RX_CRC_ERR <= ~err;
      #1;
      while (RX_RD_VALID !== 1'b1 && n < 3)
      begin
         wait_cyc(1);
         n++;
      end
      chk({2'h0, RX_RD_VALID, RX_RD_EMPTY, RX_RD_FULL, RX_RD_LEVEL},
         {3'h1, c == 0, c == 32, c[4:1]});
      if (c != 0 && !(err && en))
      begin
         chk(RX_RD_DATA, q.pop_front());
      end
      wait_cyc(2);
      c = 6'(q.size());
      chk({6'h0, RX_FULL, RX_EMPTY, RX_LEVEL_FLAG},
         {6'h0, c == 32, c == 0, c > {1'b0, RX_THRESH, 1'b1}});
   endtask

   task automatic demod_fill(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge CLK);
         d = (i == 0) ? 9'h100 : 9'($random(seed));
         send <= 1'b1;
         send_data <= d;
         if (q.size() < 32) q.push_back(d);
      end
      @(posedge CLK);
      send <= 1'b0;
      wait_cyc(3);
   endtask

   initial
   begin
      {MODEM_EN, TX_RES, EXT_FILT_EN, LPF_ORDER_EN, TX_THR_MASK, CRC_EN, RTS} = 7'h00;
      {TX_WR, RX_RD, RX_CRC_ERR, UART_RX_VALID, UART_RX_BREAK, UART_TX_READY} = 6'h00;
      IF_MODE = 2'h0;
      RX_THRESH = 4'hF;
      TX_THRESH = 4'h0;
      TX_WR_DATA = 9'h000;
      UART_RX_DATA = 9'h000;
      do_reset();
      chk({4'h0, TX_EMPTY, RX_EMPTY, TX_FULL, RX_FULL, CTS}, 9'h018);
      // Transmit FIFO through the register port, one write past full
      @(posedge CLK);
      TX_THRESH <= 4'($random(seed)) | 4'h1;
      for (int i = 0; i < 33; i++)
      begin
         @(posedge CLK);
         TX_THR_MASK <= 1'($random(seed));
         d = (i == 1) ? 9'h100 : 9'($random(seed));
         wr_tx(d);
         if (q.size() < 32) q.push_back(d);
         c = 6'(q.size());
         chk({5'h0, TX_FULL, TX_EMPTY, TX_LEVEL_FLAG, IRQ}, {5'h0, c == 32, c == 0,
            c < {TX_THRESH, 1'b0}, (c < {TX_THRESH, 1'b0}) & !TX_THR_MASK});
         chk(TX_PEEK_DATA, q[0]);
      end
      // Receive FIFO filled by the line past full, then drained, with CRC refusals
      do_reset();
      @(posedge CLK);
      MODEM_EN <= 1'b1;
      RX_THRESH <= 4'($random(seed));
      wait_cyc(2);
      demod_fill(33);
      for (int i = 0; q.size() > 0; i++)
      begin
         rd_rx(i % 5 == 2, i % 2 == 0);
      end
      rd_rx(1'b0, 1'b0);
      rd_rx(1'b0, 1'b0);
      // Serial modes: UART feeds the transmit FIFO, receive FIFO drains to UART
      for (int m = 1; m < 3; m++)
      begin
         do_reset();
         @(posedge CLK);
         IF_MODE <= 2'(m);
         MODEM_EN <= 1'b1;
         TX_THRESH <= 4'h3;
         UART_TX_READY <= 1'b0;
         for (int i = 0; i < 6; i++)
         begin
            @(posedge CLK);
            d = 9'($random(seed));
            UART_RX_VALID <= 1'b1;
            UART_RX_DATA <= d;
            UART_RX_BREAK <= (i == 2);
            TX_WR <= (i == 4);
            if (i != 2) q.push_back(d);
         end
         @(posedge CLK);
         UART_RX_VALID <= 1'b0;
         UART_RX_BREAK <= 1'b0;
         TX_WR <= 1'b0;
         wait_cyc(3);
         chk(TX_PEEK_DATA, q[0]);
         chk({7'h0, TX_EMPTY, TX_LEVEL_FLAG}, 9'h001);
         q.delete();
         demod_fill(4);
         // Random stalls on the UART side; handshake taken at the next edge
         for (int i = 0; i < 150; i++)
         begin
            @(posedge CLK);
            UART_TX_READY <= 1'($random(seed));
            #1;
            if (UART_TX_VALID === 1'b1 && UART_TX_READY === 1'b1)
               chk(UART_TX_DATA, q.size() > 0 ? q.pop_front() : 9'hxxx);
         end
         chk(9'(q.size()), 9'h000);
      end
      // Arbitration, carrier detect and modulator rate
      do_reset();
      @(posedge CLK);
      MODEM_EN <= 1'b1;
      wait_cyc(3);
      chk({5'h0, DEMOD_ENABLE, MOD_ENABLE, CTS, CARRIER_DETECT}, 9'h008);
      @(posedge CLK);
      carrier <= 1'b1;
      wait_cyc(10);
      @(posedge CLK);
      carrier <= 1'b0;
      wait_cyc(50);
      chk(9'(CARRIER_DETECT), 9'h000);
      @(posedge CLK);
      carrier <= 1'b1;
      wait_cyc(25);
      chk(9'(CARRIER_DETECT), 9'h000);
      wait_cyc(30);
      chk(9'(CARRIER_DETECT), 9'h001);
      @(posedge CLK);
      RTS <= 1'b1;
      wait_cyc(5);
      chk({6'h0, CTS, MOD_ENABLE, DEMOD_ENABLE}, 9'h001);
      @(posedge CLK);
      carrier <= 1'b0;
      wait_cyc(60);
      chk({5'h0, CARRIER_DETECT, CTS, MOD_ENABLE, DEMOD_ENABLE}, 9'h006);
      // Empty FIFO: mark tone, 16 or 64 steps per half mark period
      for (int r = 0; r < 2; r++)
      begin
         @(posedge CLK);
         TX_RES <= 1'(r);
         wait_cyc(200);
         n0 = stb_count;
         wait_cyc(16667);
         n0 = stb_count - n0 - (r == 1 ? 64 : 16);
         chk(9'(n0 >= -2 && n0 <= 2), 9'h001);
         chk(9'(TX_EMPTY), 9'h001);
      end
      chk(9'(peak_hi), 9'h07F);
      chk(9'(peak_lo), 9'h181);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge CLK);
         EXT_FILT_EN <= k[0];
         LPF_ORDER_EN <= k[1];
         wait_cyc(2);
         chk({7'h0, FILT_EXT_SEL, LPF_ENABLE}, {7'h0, k[0], k[1]});
      end
      @(posedge CLK);
      MODEM_EN <= 1'b0;
      wait_cyc(2);
      chk({6'h0, CTS, MOD_ENABLE, DEMOD_ENABLE}, 9'h000);
      test_done();
   end
endmodule

// File: hw/fskm_fifo.sv
`timescale 1ns/1ps
module fskm_fifo import fskm_pkg::*;
#(
   parameter int W = FIFO_WIDTH,
   parameter int D = FIFO_DEPTH,
   parameter int AW = $clog2(D)
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Write side
   input wire logic push,
   input wire logic [W-1:0] push_data,
   // Read side
   input wire logic pop,
   output logic [W-1:0] head,
   output logic [AW:0] count,
   output logic full,
   output logic empty
);
   typedef struct packed
   {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fskm_fifo_t;
   fskm_fifo_t s_reg;
   fskm_fifo_t s_next;
   logic do_push;
   logic do_pop;

   // Full drops the new entry, empty ignores a pop
   always_comb
   begin
      s_next = s_reg;
      do_pop = pop && (s_reg.cnt != '0);
      do_push = push && (s_reg.cnt != (AW + 1)'(D));
      if (do_push)
      begin
         s_next.mem[s_reg.wp] = push_data;
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (do_pop)
         s_next.rp = s_reg.rp + 1'b1;
      if (do_push && !do_pop)
         s_next.cnt = s_reg.cnt + 1'b1;
      else if (do_pop && !do_push)
         s_next.cnt = s_reg.cnt - 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign head = s_reg.mem[s_reg.rp];
   assign count = s_reg.cnt;
   assign full = (s_reg.cnt == (AW + 1)'(D));
   assign empty = (s_reg.cnt == '0);
endmodule

// File: hw/fskm_mod.sv
`timescale 1ns/1ps
module fskm_mod import fskm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic base_tick,
   input wire logic enable,
   input wire logic hi_res,
   // Transmit FIFO head
   input wire logic fifo_avail,
   input wire logic [8:0] fifo_data,
   output logic fifo_pop,
   // Sample output
   output logic [7:0] sample,
   output logic sample_stb,
   output logic busy
);
   typedef struct packed
   {
      logic busy;
      logic [3:0] bit_idx;
      logic [9:0] tick_cnt;
      logic [10:0] shift;
      logic [15:0] phase;
      logic [7:0] sample;
      logic stb;
   } fskm_mod_t;
   fskm_mod_t s_reg;
   fskm_mod_t s_next;
   logic cur_bit;
   logic [15:0] ph;
   logic [6:0] idx_new;

   // Idle line sends mark; a character is start, 8 data, stored parity, stop
   always_comb
   begin
      s_next = s_reg;
      s_next.stb = 1'b0;
      fifo_pop = 1'b0;
      cur_bit = s_reg.busy ? s_reg.shift[0] : 1'b1;
      ph = s_reg.phase + (cur_bit ? MARK_INC : SPACE_INC);
      idx_new = hi_res ? ph[15:9] : {ph[15:11], 2'b00};
      if (!enable)
      begin
         s_next = '0;
      end
      else if (base_tick)
      begin
         s_next.phase = ph;
         if (idx_new != (hi_res ? s_reg.phase[15:9] : {s_reg.phase[15:11], 2'b00}))
         begin
            s_next.sample = fskm_sine(idx_new);
            s_next.stb = 1'b1;
         end
         if (s_reg.tick_cnt == 10'(BIT_TICKS - 1))
         begin
            s_next.tick_cnt = '0;
            s_next.shift = {1'b1, s_reg.shift[10:1]};
            s_next.bit_idx = s_reg.bit_idx + 1'b1;
            if (s_reg.busy && s_reg.bit_idx == 4'(CHAR_BITS - 1))
               s_next.busy = 1'b0;
            if ((!s_reg.busy || s_reg.bit_idx == 4'(CHAR_BITS - 1)) && fifo_avail)
            begin
               fifo_pop = 1'b1;
               s_next.busy = 1'b1;
               s_next.bit_idx = '0;
               s_next.shift = {1'b1, fifo_data[8], fifo_data[7:0], 1'b0};
            end
         end
         else
            s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign sample = s_reg.sample;
   assign sample_stb = s_reg.stb;
   assign busy = s_reg.busy;
endmodule

// File: hw/fskm_pkg.sv
package fskm_pkg;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 9;
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int BASE_HZ = 1_228_800;
   localparam int MARK_HZ = 1200;
   localparam int SPACE_HZ = 2200;
   localparam int BAUD = 1200;
   // Base ticks per bit time and phase steps per base tick (16-bit phase)
   localparam int BIT_TICKS = BASE_HZ / BAUD;
   localparam logic [15:0] MARK_INC = 16'((MARK_HZ * 65536 + BASE_HZ / 2) / BASE_HZ);
   localparam logic [15:0] SPACE_INC = 16'((SPACE_HZ * 65536 + BASE_HZ / 2) / BASE_HZ);
   localparam int CHAR_BITS = 11;
   // Carrier detect must hold this long before it changes
   localparam int CD_FILT_NS = 1000;
   localparam int CD_FILT_CYC = (CD_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [25:0] BASE_ACC_INC = 26'(BASE_HZ);
   localparam logic [25:0] BASE_ACC_WRAP = 26'(CLK_HZ);
   // Quarter sine, entries 0..32, entry 0 in the low byte
   localparam logic [263:0] SINE_Q =
      264'h7F7F7E7E7D7B7A787573706D6A66625E5A55514C47413C36312B251F19130C0600;

   typedef enum logic [1:0]
   {
      IFM_SPI = 2'b00,
      IFM_SPI_UART = 2'b01,
      IFM_BREAK_MSG = 2'b10
   } fskm_ifmode_t;

   typedef enum logic [1:0]
   {
      ARB_OFF = 2'b00,
      ARB_RX = 2'b01,
      ARB_TX = 2'b10
   } fskm_arb_t;

   // Signed 8-bit sine sample for a 7-bit phase index
   function automatic logic [7:0] fskm_sine(input logic [6:0] idx);
      logic [5:0] k;
      logic [7:0] m;
      k = idx[5] ? (6'h20 - {1'b0, idx[4:0]}) : {1'b0, idx[4:0]};
      m = SINE_Q[{k, 3'b000} +: 8];
      return idx[6] ? (~m + 8'h01) : m;
   endfunction
endpackage

// File: hw/fskm_top.sv
`timescale 1ns/1ps
module fskm_top import fskm_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Configuration
   input wire logic MODEM_EN,
   input wire logic [1:0] IF_MODE,
   input wire logic TX_RES,
   input wire logic EXT_FILT_EN,
   input wire logic LPF_ORDER_EN,
   input wire logic [3:0] RX_THRESH,
   input wire logic [3:0] TX_THRESH,
   input wire logic TX_THR_MASK,
   input wire logic CRC_EN,
   input wire logic RTS,
   // Register access strobes
   input wire logic TX_WR,
   input wire logic [8:0] TX_WR_DATA,
   input wire logic RX_RD,
   input wire logic RX_CRC_ERR,
   output logic [8:0] RX_RD_DATA,
   output logic RX_RD_VALID,
   output logic RX_RD_EMPTY,
   output logic RX_RD_FULL,
   output logic [3:0] RX_RD_LEVEL,
   output logic [8:0] TX_PEEK_DATA,
   // Serial link characters
   input wire logic UART_RX_VALID,
   input wire logic [8:0] UART_RX_DATA,
   input wire logic UART_RX_BREAK,
   output logic UART_TX_VALID,
   output logic [8:0] UART_TX_DATA,
   input wire logic UART_TX_READY,
   // Line side
   input wire logic DEMOD_VALID,
   input wire logic [8:0] DEMOD_DATA,
   input wire logic CARRIER_ABOVE_ON,
   input wire logic CARRIER_ABOVE_OFF,
   output logic [7:0] MOD_SAMPLE,
   output logic MOD_SAMPLE_STB,
   output logic MOD_ENABLE,
   output logic DEMOD_ENABLE,
   output logic CARRIER_DETECT,
   output logic CTS,
   output logic FILT_EXT_SEL,
   output logic LPF_ENABLE,
   // FIFO status and interrupt
   output logic TX_FULL,
   output logic TX_EMPTY,
   output logic TX_LEVEL_FLAG,
   output logic RX_FULL,
   output logic RX_EMPTY,
   output logic RX_LEVEL_FLAG,
   output logic IRQ
);
   typedef struct packed
   {
      fskm_arb_t arb;
      logic cd;
      logic [5:0] cd_cnt;
      logic [25:0] base_acc;
      logic base_tick;
      logic [8:0] rd_data;
      logic rd_valid;
      logic rd_empty;
      logic rd_full;
      logic [3:0] rd_level;
      logic [8:0] peek;
      logic tx_full;
      logic tx_empty;
      logic tx_flag;
      logic rx_full;
      logic rx_empty;
      logic rx_flag;
      logic irq;
      logic utx_valid;
      logic [8:0] utx_data;
      logic filt_ext;
      logic lpf_en;
   } fskm_top_t;
   fskm_top_t s_reg;
   fskm_top_t s_next;

   logic tx_push;
   logic [8:0] tx_push_data;
   logic tx_pop;
   logic [8:0] tx_head;
   logic [5:0] tx_count;
   logic tx_full;
   logic tx_empty;
   logic rx_push;
   logic rx_pop;
   logic [8:0] rx_head;
   logic [5:0] rx_count;
   logic rx_full;
   logic rx_empty;
   logic rd_fire;
   logic rd_deq;
   logic utx_load;
   logic spi_mode;
   logic uart_mode;
   logic mod_busy;
   logic cd_want;

   assign spi_mode = (IF_MODE == IFM_SPI);
   assign uart_mode = (IF_MODE == IFM_SPI_UART) || (IF_MODE == IFM_BREAK_MSG);

   // Transmit FIFO source: host writes in register mode, plain characters in the two serial modes
   always_comb
   begin
      tx_push = 1'b0;
      tx_push_data = TX_WR_DATA;
      if (spi_mode)
         tx_push = TX_WR;
      else if (uart_mode)
      begin
         tx_push = UART_RX_VALID && !UART_RX_BREAK;
         tx_push_data = UART_RX_DATA;
      end
   end

   // A register read not refused for a CRC error, or a serial output load, dequeues; a write to the read register has no path here
   assign rd_fire = RX_RD && spi_mode;
   assign rd_deq = rd_fire && !rx_empty && !(CRC_EN && RX_CRC_ERR);
   assign utx_load = uart_mode && !rx_empty && (!s_reg.utx_valid || UART_TX_READY);
   assign rx_pop = rd_deq || utx_load;
   // Demodulated characters only land while the demodulator owns the line
   assign rx_push = DEMOD_VALID && (s_reg.arb == ARB_RX);

   fskm_fifo u_tx_fifo
   (
      .clk(CLK),
      .rstn(RSTN),
      .push(tx_push),
      .push_data(tx_push_data),
      .pop(tx_pop),
      .head(tx_head),
      .count(tx_count),
      .full(tx_full),
      .empty(tx_empty)
   );

   fskm_fifo u_rx_fifo
   (
      .clk(CLK),
      .rstn(RSTN),
      .push(rx_push),
      .push_data(DEMOD_DATA),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_count),
      .full(rx_full),
      .empty(rx_empty)
   );

   fskm_mod u_mod
   (
      .clk(CLK),
      .rstn(RSTN),
      .base_tick(s_reg.base_tick),
      .enable(s_reg.arb == ARB_TX),
      .hi_res(TX_RES),
      .fifo_avail(!tx_empty),
      .fifo_data(tx_head),
      .fifo_pop(tx_pop),
      .sample(MOD_SAMPLE),
      .sample_stb(MOD_SAMPLE_STB),
      .busy(mod_busy)
   );

   // Next state of the top: divider, carrier filter, arbiter, read port, flags
   always_comb
   begin
      s_next = s_reg;
      // Fractional divider gives the 1.2288 MHz base as a one-cycle enable
      s_next.base_tick = 1'b0;
      if (s_reg.base_acc + BASE_ACC_INC >= BASE_ACC_WRAP)
      begin
         s_next.base_acc = s_reg.base_acc + BASE_ACC_INC - BASE_ACC_WRAP;
         s_next.base_tick = 1'b1;
      end
      else
         s_next.base_acc = s_reg.base_acc + BASE_ACC_INC;
      // Upper threshold to assert, lower to release, both held for the filter time
      cd_want = s_reg.cd ? CARRIER_ABOVE_OFF : CARRIER_ABOVE_ON;
      if (s_reg.arb != ARB_RX)
      begin
         s_next.cd = 1'b0;
         s_next.cd_cnt = '0;
      end
      else if (cd_want == s_reg.cd)
         s_next.cd_cnt = '0;
      else if (s_reg.cd_cnt == 6'(CD_FILT_CYC - 1))
      begin
         s_next.cd = cd_want;
         s_next.cd_cnt = '0;
      end
      else
         s_next.cd_cnt = s_reg.cd_cnt + 1'b1;
      // Half-duplex arbiter; going from transmit to receive waits for the character in flight, dropping MODEM_EN does not
      case (s_reg.arb)
         ARB_OFF:
         begin
            if (MODEM_EN)
               s_next.arb = ARB_RX;
         end
         ARB_RX:
         begin
            if (!MODEM_EN)
               s_next.arb = ARB_OFF;
            else if (RTS && !s_reg.cd)
               s_next.arb = ARB_TX;
         end
         ARB_TX:
         begin
            if (!MODEM_EN)
               s_next.arb = ARB_OFF;
            else if (!RTS && !mod_busy)
               s_next.arb = ARB_RX;
         end
         default:
            s_next.arb = ARB_OFF;
      endcase
      // Read answer reflects the FIFO as it stood before this dequeue
      s_next.rd_valid = rd_fire;
      if (rd_fire)
      begin
         s_next.rd_data = rx_head;
         s_next.rd_empty = rx_empty;
         s_next.rd_full = rx_full;
         s_next.rd_level = rx_count[4:1];
      end
      s_next.peek = tx_head;
      // Serial output holds a character until the far side takes it
      if (utx_load)
      begin
         s_next.utx_valid = 1'b1;
         s_next.utx_data = rx_head;
      end
      else if (UART_TX_READY)
         s_next.utx_valid = 1'b0;
      s_next.tx_full = tx_full;
      s_next.tx_empty = tx_empty;
      s_next.rx_full = rx_full;
      s_next.rx_empty = rx_empty;
      s_next.rx_flag = rx_count > {1'b0, RX_THRESH, 1'b1};
      s_next.tx_flag = tx_count < {1'b0, TX_THRESH, 1'b0};
      // Flags are not sticky, so the pin follows the live level
      s_next.irq = s_reg.tx_flag && !TX_THR_MASK;
      s_next.filt_ext = EXT_FILT_EN;
      s_next.lpf_en = LPF_ORDER_EN;
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // Outputs come straight from the state register
   assign RX_RD_DATA = s_reg.rd_data;
   assign RX_RD_VALID = s_reg.rd_valid;
   assign RX_RD_EMPTY = s_reg.rd_empty;
   assign RX_RD_FULL = s_reg.rd_full;
   assign RX_RD_LEVEL = s_reg.rd_level;
   assign TX_PEEK_DATA = s_reg.peek;
   assign UART_TX_VALID = s_reg.utx_valid;
   assign UART_TX_DATA = s_reg.utx_data;
   assign MOD_ENABLE = (s_reg.arb == ARB_TX);
   assign DEMOD_ENABLE = (s_reg.arb == ARB_RX);
   assign CTS = (s_reg.arb == ARB_TX);
   assign CARRIER_DETECT = s_reg.cd;
   assign FILT_EXT_SEL = s_reg.filt_ext;
   assign LPF_ENABLE = s_reg.lpf_en;
   assign TX_FULL = s_reg.tx_full;
   assign TX_EMPTY = s_reg.tx_empty;
   assign TX_LEVEL_FLAG = s_reg.tx_flag;
   assign RX_FULL = s_reg.rx_full;
   assign RX_EMPTY = s_reg.rx_empty;
   assign RX_LEVEL_FLAG = s_reg.rx_flag;
   assign IRQ = s_reg.irq;

   // Checks on the block's own behaviour
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   AST_HALF_DUPLEX: assert property (!(MOD_ENABLE && DEMOD_ENABLE))
      else $error("modulator and demodulator enabled together");
   AST_CTS_NO_CD: assert property (CTS |-> !CARRIER_DETECT)
      else $error("carrier detect high while clear to send");
   AST_RTS_START: assert property
      ((DEMOD_ENABLE && MODEM_EN && RTS && !CARRIER_DETECT) |=> CTS && !DEMOD_ENABLE)
      else $error("send request not granted");
   // Flags lag by one cycle, so the first edge after reset release has no valid past
   AST_RX_FLAG: assert property
      (RSTN |=> RX_LEVEL_FLAG == ($past(rx_count) > {1'b0, $past(RX_THRESH), 1'b1}))
      else $error("receive threshold flag wrong");
   AST_TX_FLAG: assert property
      (RSTN |=> TX_LEVEL_FLAG == ($past(tx_count) < {1'b0, $past(TX_THRESH), 1'b0}))
      else $error("transmit threshold flag wrong");
   AST_RD_LEVEL: assert property
      (rd_fire |=> RX_RD_VALID && RX_RD_LEVEL == $past(rx_count[4:1])
         && RX_RD_EMPTY == $past(rx_empty))
      else $error("read status not taken before dequeue");
   AST_CRC_HOLD: assert property
      ((rd_fire && CRC_EN && RX_CRC_ERR && !rx_push && !utx_load) |=> $stable(rx_count))
      else $error("dequeue despite CRC error");
   AST_EMPTY_READ: assert property
      ((rd_fire && rx_empty && !rx_push) |=> rx_count == 6'h00 ##1 RX_RD_EMPTY)
      else $error("empty read disturbed FIFO");
   AST_FULL_DROP: assert property
      ((tx_full && !tx_pop) |=> tx_count == 6'h20 && $stable(tx_head))
      else $error("full transmit FIFO accepted entry");
   AST_IRQ: assert property
      ((TX_LEVEL_FLAG && !TX_THR_MASK) |=> IRQ)
      else $error("unmasked transmit flag without interrupt");
   AST_RD_DATA: assert property
      (rd_fire |=> RX_RD_DATA == $past(rx_head))
      else $error("read data not the stored entry");
   AST_PEEK: assert property
      (RSTN |=> TX_PEEK_DATA == $past(tx_head))
      else $error("transmit peek not the head entry");
   AST_TX_NO_DEQ: assert property
      ((!MOD_ENABLE && !tx_push) |=> $stable(tx_count))
      else $error("transmit FIFO dequeued without the modulator");
   AST_CD_OFF: assert property
      (!DEMOD_ENABLE |=> !CARRIER_DETECT)
      else $error("carrier detect high outside receive");
   AST_BREAK_SKIP: assert property
      ((uart_mode && UART_RX_VALID && UART_RX_BREAK && !tx_pop) |=> $stable(tx_count))
      else $error("break character entered transmit FIFO");
   AST_UART_HOLD: assert property
      ((UART_TX_VALID && !UART_TX_READY) |=> UART_TX_VALID && $stable(UART_TX_DATA))
      else $error("serial output dropped before acceptance");
   AST_FILT_CFG: assert property
      (RSTN |=> FILT_EXT_SEL == $past(EXT_FILT_EN) && LPF_ENABLE == $past(LPF_ORDER_EN))
      else $error("filter configuration not followed");

   COV_TX_GRANT: cover property (DEMOD_ENABLE ##1 CTS);
   COV_READ_DATA: cover property (rd_deq ##1 RX_RD_VALID && !RX_RD_EMPTY);
   COV_TX_FULL: cover property (tx_full && tx_push);
   COV_CD_RISE: cover property (!CARRIER_DETECT ##1 CARRIER_DETECT);
   COV_UART_OUT: cover property (UART_TX_VALID && UART_TX_READY);
endmodule
